// ---- design/mcs_cycle.sv ----
// measurement cycle sequencer with gate hold and output stage
//
// Contract
// [R1] exposures start one repetition period apart
// [R2] change during exposure shows after about two periods
// [R3] change just after exposure shows within three periods
// [R4] with gate in use, exposure starts on gate falling; response two periods
// [R5] gate sampled before each laser pulse; low starts next measurement at once
// [R6] gate high mid-cycle: finish cycle, start no new one
// [R7] gate high holds the device as long as it stays high
// [R8] laser runs at reduced power while in hold
// [R9] outputs stay frozen during hold until next measurement completes
// [R10] controller keeps gate low at least 5 us to resume
// [R11] first cycle after hold is lengthened by the 5 us low time
// [R12] no object: outputs keep last valid value
// [R13] analog output selects current or voltage mode
// [R14] height maps linearly over range: 0-10 V or 4 mA plus 16 mA span
// [R15] switch output single point or window, normal or inverted polarity
// [R16] hysteresis is sensing distance times relative factor
// [R17] alarm high while no object in range
// [R18] serial interface active: outputs driven as if no object present
// [R19] gate synchronised before sampling
// [R20] gate low time counted before release
`timescale 1ns/1ps
`default_nettype none
module mcs_cycle
	import mcs_pkg::*;
#(
	parameter int unsigned GATE_LOW = GATE_LOW_CYC
) (
	input wire logic i_ref_clk,
	input wire logic i_resetn,
	input wire logic i_gate,
	input wire logic [PER_W-1:0] i_period,
	input wire mcs_cfg_t i_cfg,
	input wire mcs_range_t i_range,
	input wire logic i_meas_valid,
	input wire logic i_object_present,
	input wire logic [VAL_W-1:0] i_height,
	output logic o_laser_on,
	output logic o_laser_dim,
	output logic o_expose,
	output logic o_result_strobe,
	output logic o_analog_current,
	output logic [DAC_W-1:0] o_analog_code,
	output logic o_switch,
	output logic o_alarm_line,
	output logic o_hold
);
	initial begin
		if (VAL_W > 16 || DAC_W != 16) $error("mcs_cycle: unsupported widths");
	end

	mcs_state_t state;
	logic gate_high;
	logic released;
	logic [PER_W-1:0] per_cnt;
	logic period_done;
	logic [VAL_W-1:0] last_height;
	logic last_present;
	logic sw_state;
	logic [DAC_W-1:0] next_code;
	logic [VAL_W-1:0] hyst;
	logic [VAL_W-1:0] sensing_distance;

	mcs_gate_sync #(
		.LOW_CYC(GATE_LOW)
	) u_gate (
		.i_ref_clk(i_ref_clk),
		.i_resetn(i_resetn),
		.i_gate(i_gate),
		.o_gate_high(gate_high),
		.o_released(released)
	);

	function automatic logic [VAL_W-1:0] sat_sub(input logic [VAL_W-1:0] a,
			input logic [VAL_W-1:0] b);
		return (a > b) ? a - b : VAL_ZERO;
	endfunction : sat_sub

	// linear map of height onto the dac span, endpoints from the (limited) range
	function automatic logic [DAC_W-1:0] scale(input logic [VAL_W-1:0] h,
			input logic [VAL_W-1:0] lo, input logic [VAL_W-1:0] hi,
			input logic [DAC_W-1:0] span, input logic [DAC_W-1:0] base);
		logic [VAL_W-1:0] num;
		logic [VAL_W-1:0] den;
		logic [31:0] prod;
		num = sat_sub(h, lo);
		den = sat_sub(hi, lo);
		prod = 32'h0000_0000;
		if (den == VAL_ZERO) begin
			return base;
		end
		if (num > den) begin
			num = den;
		end
		prod = (32'(num) * 32'(span)) / 32'(den);
		return base + prod[DAC_W-1:0];
	endfunction : scale

	// period counter paces exposures; it restarts on every exposure start
	assign period_done = (per_cnt >= i_period - 32'h0000_0001);

	always_ff @(posedge i_ref_clk) begin
		if (!i_resetn) begin
			per_cnt <= PER_ZERO;
		end else if (state == MCS_HOLD || (state == MCS_CALC && period_done)) begin
			per_cnt <= PER_ZERO; // [R1]
		end else begin
			per_cnt <= per_cnt + 32'h0000_0001;
		end
	end

	// sequencer: while running, gate_high is looked at only at the pulse boundary; in hold, released is checked every cycle
	always_ff @(posedge i_ref_clk) begin
		if (!i_resetn) begin
			state <= MCS_HOLD;
		end else begin
			case (state)
				MCS_IDLE: begin
					state <= MCS_EXPOSE;
				end
				MCS_EXPOSE: begin
					if (i_meas_valid) begin
						state <= MCS_CALC;
					end
				end
				MCS_CALC: begin
					if (period_done) begin
						if (gate_high) begin
							state <= MCS_HOLD; // [R6] [R7]
						end else begin
							state <= MCS_EXPOSE; // [R5] [R1]
						end
					end
				end
				MCS_HOLD: begin
					// wait out the full low time, so the first cycle is later by it
					if (released) begin
						state <= MCS_EXPOSE; // [R4] [R11] [R10]
					end
				end
				default: begin
					state <= MCS_HOLD;
				end
			endcase
		end
	end

	always_ff @(posedge i_ref_clk) begin
		if (!i_resetn) begin
			o_laser_on <= 1'b0;
			o_laser_dim <= 1'b1;
			o_expose <= 1'b0;
			o_hold <= 1'b1;
		end else begin
			o_expose <= (state == MCS_EXPOSE);
			o_laser_on <= (state == MCS_EXPOSE);
			o_laser_dim <= (state == MCS_HOLD); // [R8]
			o_hold <= (state == MCS_HOLD); // [R7]
		end
	end

	// latch the last valid result; no-object results leave the height alone
	always_ff @(posedge i_ref_clk) begin
		if (!i_resetn) begin
			last_height <= VAL_ZERO;
			last_present <= 1'b0;
			o_result_strobe <= 1'b0;
		end else begin
			o_result_strobe <= 1'b0;
			if (state == MCS_EXPOSE && i_meas_valid) begin
				o_result_strobe <= 1'b1; // [R2] [R3]
				last_present <= i_object_present;
				if (i_object_present) begin
					last_height <= i_height; // [R12] [R9]
				end
			end
		end
	end

	assign sensing_distance = sat_sub(i_range.range_end, i_range.switch_point); // [R16]
	assign hyst = VAL_W'((32'(sensing_distance) * 32'(i_cfg.hyst_pct)) / 32'd100); // [R16]

	always_comb begin
		if (i_cfg.analog_current) begin
			next_code = scale(last_height, i_range.range_start, i_range.range_end,
				DAC_16MA, DAC_4MA); // [R14] [R13]
		end else begin
			next_code = scale(last_height, i_range.range_start, i_range.range_end,
				DAC_FULL, 16'h0000); // [R14]
		end
	end

	// switch state with hysteresis; window uses switch_point..window_far
	// updated with the result itself so the output stage sees it on the strobe
	always_ff @(posedge i_ref_clk) begin
		if (!i_resetn) begin
			sw_state <= 1'b0;
		end else if (state == MCS_EXPOSE && i_meas_valid && i_object_present) begin
			if (!i_cfg.window_mode) begin
				if (i_height >= i_range.switch_point) begin
					sw_state <= 1'b1; // [R15]
				end else if (i_height < sat_sub(i_range.switch_point, hyst)) begin
					sw_state <= 1'b0; // [R16]
				end
			end else begin
				if (i_height >= i_range.switch_point && i_height <= i_range.window_far) begin
					sw_state <= 1'b1; // [R15]
				end else if (i_height < sat_sub(i_range.switch_point, hyst)
						|| i_height > i_range.window_far + hyst) begin
					sw_state <= 1'b0;
				end
			end
		end
	end

	// outputs refresh only on a completed measurement or with serial active, hence frozen through hold while serial is inactive
	always_ff @(posedge i_ref_clk) begin
		if (!i_resetn) begin
			o_analog_code <= 16'h0000;
			o_analog_current <= 1'b0;
			o_switch <= 1'b0;
			o_alarm_line <= 1'b0;
		end else if (i_cfg.serial_active) begin
			o_analog_code <= 16'h0000; // [R18]
			o_analog_current <= i_cfg.analog_current;
			o_switch <= i_cfg.invert;
			o_alarm_line <= 1'b1;
		end else if (o_result_strobe) begin
			o_analog_code <= next_code; // [R9] [R12]
			o_analog_current <= i_cfg.analog_current; // [R13]
			o_switch <= sw_state ^ i_cfg.invert; // [R15]
			o_alarm_line <= !last_present; // [R17]
		end
	end

	a_hold_dims_laser: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
		o_hold |-> o_laser_dim && !o_laser_on) // [R8]
		else $error("laser not dimmed in hold");

	a_hold_freeze_out: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
		(state == MCS_HOLD && !i_cfg.serial_active && $past(state == MCS_HOLD))
		|-> $stable(o_analog_code) && $stable(o_switch)) // [R9]
		else $error("outputs changed during hold");

	a_gate_stops_cycle: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
		(state == MCS_CALC && period_done && gate_high) |=> state == MCS_HOLD) // [R6]
		else $error("new cycle started with gate high");

	a_gate_low_runs: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
		(state == MCS_CALC && period_done && !gate_high) |=> state == MCS_EXPOSE) // [R5]
		else $error("cycle not started with gate low");

	a_hold_release: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
		(state == MCS_HOLD && !released) |=> state == MCS_HOLD) // [R7]
		else $error("hold left before release");

	a_alarm_no_obj: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
		(o_result_strobe && !last_present && !i_cfg.serial_active) |=> o_alarm_line) // [R17]
		else $error("alarm not raised without object");

	a_serial_blank: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
		i_cfg.serial_active |=> o_alarm_line && o_analog_code == 16'h0000) // [R18]
		else $error("outputs live while serial active");

	a_no_object_keep: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
		(state == MCS_EXPOSE && i_meas_valid && !i_object_present) |=> $stable(last_height)) // [R12]
		else $error("height changed without object");
endmodule : mcs_cycle
`default_nettype wire

// ---- inc/mcs_pkg.sv ----
// shared constants and types for the measurement cycle sequencer
package mcs_pkg;
	localparam int unsigned CLK_MHZ = 250;
	localparam int unsigned GATE_LOW_MIN_NS = 5000;
	localparam int unsigned GATE_LOW_CYC = (GATE_LOW_MIN_NS * CLK_MHZ + 999) / 1000;
	localparam int unsigned VAL_W = 16;
	localparam int unsigned PER_W = 32;
	localparam int unsigned DAC_W = 16;
	localparam logic [DAC_W-1:0] DAC_FULL = 16'hFFFF;
	localparam logic [DAC_W-1:0] DAC_4MA = 16'h3333;
	localparam logic [DAC_W-1:0] DAC_16MA = 16'hCCCC;
	localparam logic [VAL_W-1:0] VAL_ZERO = 16'h0000;
	localparam logic [PER_W-1:0] PER_ZERO = 32'h0000_0000;

	typedef enum logic [1:0] {
		MCS_IDLE = 2'b00,
		MCS_EXPOSE = 2'b01,
		MCS_CALC = 2'b10,
		MCS_HOLD = 2'b11
	} mcs_state_t;

	typedef struct packed {
		logic analog_current;
		logic window_mode;
		logic invert;
		logic serial_active;
		logic [7:0] hyst_pct;
	} mcs_cfg_t;

	typedef struct packed {
		logic [VAL_W-1:0] range_start;
		logic [VAL_W-1:0] range_end;
		logic [VAL_W-1:0] switch_point;
		logic [VAL_W-1:0] window_far;
	} mcs_range_t;
endpackage : mcs_pkg

// ---- design/mcs_gate_sync.sv ----
// gate input synchroniser and low-time qualifier
`timescale 1ns/1ps
`default_nettype none
module mcs_gate_sync
	import mcs_pkg::*;
#(
	parameter int unsigned LOW_CYC = GATE_LOW_CYC
) (
	input wire logic i_ref_clk,
	input wire logic i_resetn,
	input wire logic i_gate,
	output logic o_gate_high,
	output logic o_released
);
	initial begin
		if (LOW_CYC < 1 || LOW_CYC > 65535) $error("mcs_gate_sync: LOW_CYC out of range");
	end
	logic meta;
	logic sync;
	logic [15:0] low_cnt;

	always_ff @(posedge i_ref_clk) begin
		if (!i_resetn) begin
			meta <= 1'b1;
			sync <= 1'b1;
		end else begin
			meta <= i_gate; // [R19]
			sync <= meta;
		end
	end

	// released only after the low level has stood its full minimum time
	always_ff @(posedge i_ref_clk) begin
		if (!i_resetn) begin
			low_cnt <= 16'h0000;
			o_released <= 1'b0;
			o_gate_high <= 1'b1;
		end else begin
			o_gate_high <= sync;
			if (sync) begin
				low_cnt <= 16'h0000;
				o_released <= 1'b0;
			end else if (low_cnt < 16'(LOW_CYC)) begin
				low_cnt <= low_cnt + 16'h0001; // [R20]
				o_released <= (low_cnt == 16'(LOW_CYC - 1));
			end else begin
				o_released <= 1'b1;
			end
		end
	end

	a_release_time: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
		$rose(o_released) |-> $past(!sync, LOW_CYC)) // [R20]
		else $error("gate released before minimum low time");
endmodule : mcs_gate_sync
`default_nettype wire

// ---- testbench/mcs_ctrl_model.sv ----
// superordinate controller model: drives the gate pin
`timescale 1ns/1ps
`default_nettype none
module mcs_ctrl_model #(
	parameter int unsigned LOW_MIN = 8
) (
	input wire logic i_ref_clk,
	input wire logic i_hold_req,
	output logic o_gate
);
	int unsigned low_cnt;
	initial begin
		o_gate = 1'b1;
		low_cnt = 0;
	end
	always @(posedge i_ref_clk) begin
		// a new hold request waits until the gate has been low long enough
		if (!o_gate && low_cnt < LOW_MIN) begin
			low_cnt <= low_cnt + 1;
		end else if (o_gate != i_hold_req) begin
			o_gate <= #1 i_hold_req;
			low_cnt <= 0;
		end
	end
endmodule : mcs_ctrl_model
`default_nettype wire

// ---- testbench/tb.sv ----
// self-checking bench for the measurement cycle sequencer
`timescale 1ns/1ps
`default_nettype none
module tb
	import mcs_pkg::*;
();
	localparam int LOW = 8;
	localparam int PER = 24;
	logic i_ref_clk, i_resetn, i_gate, i_meas_valid, i_object_present, hold_req;
	logic [PER_W-1:0] i_period;
	mcs_cfg_t i_cfg;
	mcs_range_t i_range;
	logic [VAL_W-1:0] i_height;
	logic o_laser_on, o_laser_dim, o_expose, o_result_strobe, o_analog_current;
	logic o_switch, o_alarm_line, o_hold;
	logic [DAC_W-1:0] o_analog_code;
	int mismatches, checked, n;
	time t0;
	mcs_cycle #(.GATE_LOW(LOW)) u_dut (.*);
	mcs_ctrl_model #(.LOW_MIN(LOW)) u_ctrl (.i_ref_clk(i_ref_clk), .i_hold_req(hold_req),
		.o_gate(i_gate));
	initial begin
		i_ref_clk = 1'b0;
		forever #2 i_ref_clk = ~i_ref_clk;
	end
	// measurement engine: one result three cycles into every exposure
	always @(posedge o_expose) begin
		repeat (3) @(posedge i_ref_clk);
		#1 i_meas_valid = 1'b1;
		@(posedge i_ref_clk);
		#1 i_meas_valid = 1'b0;
	end
	task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			mismatches++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : cmp
	task automatic wait_hi(ref logic s, input int lim);
		for (n = 0; n < lim && s !== 1'b1; n++) begin
			@(posedge i_ref_clk);
			#1;
		end
	endtask : wait_hi
	// two strobes, so the second result surely used the new height
	task automatic meas(input logic [VAL_W-1:0] h, input logic ob);
		int s;
		i_height = h;
		i_object_present = ob;
		s = 0;
		for (int k = 0; k < 8 * PER && s < 2; k++) begin
			@(posedge i_ref_clk);
			#1;
			if (o_result_strobe === 1'b1) s++;
		end
		cmp(s[15:0], 16'h0002);
		repeat (2) @(posedge i_ref_clk);
		#1;
	endtask : meas
	task automatic t_release;
		cmp({o_hold, o_laser_dim, o_expose}, 16'h0006);
		hold_req = 1'b0;
		wait_hi(o_expose, 4 * LOW);
		cmp(16'(n >= LOW && n <= LOW + 8), 16'h0001);
		cmp({o_laser_on, o_laser_dim, o_hold}, 16'h0004);
	endtask : t_release
	task automatic t_period;
		@(posedge o_expose);
		t0 = $time;
		@(posedge o_expose);
		cmp(16'(($time - t0) / 4), 16'(PER));
		#1;
	endtask : t_period
	task automatic t_analog;
		for (int m = 0; m < 2; m++) begin
			i_cfg.analog_current = m[0];
			meas(16'h0100, 1'b1);
			cmp(o_analog_code, m ? DAC_4MA : 16'h0000);
			cmp(o_analog_current, m[0]);
			meas(16'h1100, 1'b1);
			cmp(o_analog_code, m ? DAC_4MA + DAC_16MA : DAC_FULL);
		end
	endtask : t_analog
	task automatic t_switch;
		for (int k = 0; k < 4; k++) begin
			{i_cfg.window_mode, i_cfg.invert} = k[1:0];
			meas(16'h0C00, 1'b1);
			cmp(o_switch, !k[0]);
			meas(16'h1100, 1'b1);
			cmp(o_switch, !k[1] ^ k[0]);
			meas(16'h0100, 1'b1);
			cmp(o_switch, k[0]);
		end
		{i_cfg.window_mode, i_cfg.invert} = 2'b00;
		i_cfg.hyst_pct = 8'h32;
		meas(16'h1100, 1'b1);
		meas(16'h0600, 1'b1);
		cmp(o_switch, 1'b1);
		meas(16'h0400, 1'b1);
		cmp(o_switch, 1'b0);
		meas(16'h0600, 1'b1);
		cmp(o_switch, 1'b0);
	endtask : t_switch
	task automatic t_noobj_serial;
		meas(16'h1100, 1'b1);
		cmp(o_alarm_line, 1'b0);
		meas(16'h0100, 1'b0);
		cmp({o_alarm_line, o_analog_code}, {1'b1, DAC_FULL});
		i_cfg.serial_active = 1'b1;
		meas(16'h1100, 1'b1);
		cmp({o_alarm_line, o_analog_code, o_switch}, 18'h2_0000);
		i_cfg.serial_active = 1'b0;
	endtask : t_noobj_serial
	task automatic t_hold;
		meas(16'h1100, 1'b1);
		@(posedge o_expose);
		#1 hold_req = 1'b1;
		i_height = 16'h0100;
		wait_hi(o_result_strobe, 2 * PER);
		cmp(o_result_strobe, 1'b1);
		wait_hi(o_hold, 2 * PER);
		cmp({o_hold, o_laser_dim}, 16'h0003);
		// no result arrives in hold, so the height seen here must not leak out
		i_height = 16'h1100;
		repeat (4 * PER) @(posedge i_ref_clk);
		#1;
		// the cycle that was running when the gate rose delivered its result
		cmp({o_expose, o_laser_on, o_analog_code}, {2'b00, DAC_4MA});
		hold_req = 1'b0;
		wait_hi(o_expose, 4 * LOW);
		cmp(16'(n >= LOW && n <= LOW + 8), 16'h0001);
	endtask : t_hold
	task automatic end_of_test;
		$display("mismatches %0d checked %0d", mismatches, checked);
		if (mismatches == 0 && checked > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : end_of_test
	initial begin
		#40000;
		mismatches++;
		end_of_test();
	end
	initial begin
		{i_resetn, i_meas_valid, i_object_present, i_height} = '0;
		hold_req = 1'b1;
		i_period = PER;
		i_cfg = '0;
		i_range = {16'h0100, 16'h1100, 16'h0900, 16'h1000};
		repeat (10) @(posedge i_ref_clk);
		#1 i_resetn = 1'b1;
		t_release();
		t_period();
		t_analog();
		t_switch();
		t_noobj_serial();
		t_hold();
		end_of_test();
	end
endmodule : tb
`default_nettype wire
